// ---- common/xim_map.svh ----
/*
  Register offsets, field positions and reset values of the extended
  interrupt mask block. Assumes inclusion by bare name from rtl files.
*/
`ifndef XIM_MAP_SVH
`define XIM_MAP_SVH
// ----------------------------------------------------------------------
// register addresses on the special-function-register bus
// ----------------------------------------------------------------------
`define XIM_ADDR_PRIO       8'hB8
`define XIM_ADDR_EXT_EN     8'hE6
// ----------------------------------------------------------------------
// reset values, write masks and fixed-ones bits
// ----------------------------------------------------------------------
`define XIM_RST_PRIO        8'hC0
`define XIM_RST_EXT_EN      8'h00
`define XIM_PRIO_FIXED_ONES 8'hC0
`define XIM_PRIO_WR_MASK    8'h3F
`define XIM_EXT_EN_WR_MASK  8'h3F
// ----------------------------------------------------------------------
// field positions of the extended enable register
// ----------------------------------------------------------------------
`define XIM_BIT_CMP_RISE    5
`define XIM_BIT_CMP_FALL    4
`define XIM_BIT_CTR_ARRAY   3
`define XIM_BIT_ADC_DONE    2
`define XIM_BIT_ADC_WIN     1
`define XIM_BIT_TWOWIRE     0
`define XIM_NUM_SRC         6
`endif

// ---- common/xim_pkg.sv ----
/*
  Types shared by the extended interrupt mask block.
  Assumes the map header defines the source count.
*/
`include "xim_map.svh"
package xim_pkg;
  // --------------------------------------------------------------------
  // sfr bus request
  // --------------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } xim_sfr_req_t;
  typedef logic [`XIM_NUM_SRC-1:0] xim_src_vec_t;
endpackage

// ---- rtl/xim_gate.sv ----
/*
  One pending-flag gate: pass a request only when flag, own enable and
  global enable are all set. Assumes a single synchronous clock.
*/
`timescale 1ns/1ns
module xim_gate (
  input  wire logic clk_sys_in,  // system clock
  input  wire logic rst_in,      // sync reset, active high
  input  wire logic pend_in,     // pending flag of the source
  input  wire logic en_in,       // individual enable bit
  input  wire logic glob_in,     // global enable
  output logic      req_out      // registered request to core
);
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      req_out <= 1'b0;
    else
      req_out <= pend_in & en_in & glob_in; // RULE7 RULE8
  end
endmodule

// ---- rtl/xim_top.sv ----
/*
  Extended interrupt mask block: extended enable register, legacy
  priority register, per-source request gating toward the core.
  Assumes a byte-wide sfr bus in the system clock domain; pending flags
  stay in their peripherals and are never altered here.
*/
// Behaviour
// RULE1 - enable bit 5 gates comparator rising-edge request
// RULE2 - enable bit 4 gates comparator falling-edge flag
// RULE3 - enable bit 3 is one common mask for all counter-array sources
// RULE4 - enable bit 2 gates adc conversion-complete flag
// RULE5 - enable bit 1 gates adc window-compare flag
// RULE6 - enable bit 0 gates two-wire bus flag
// RULE7 - global enable low blocks every source regardless of masks
// RULE8 - request needs flag, own enable and global enable; flag untouched
`timescale 1ns/1ns
`include "xim_map.svh"
module xim_top #(
  parameter int NUM_CTR = 4                  // counter-array sources
) (
  input  wire logic                 clk_sys_in,     // system clock
  input  wire logic                 rst_in,         // sync reset
  input  wire xim_pkg::xim_sfr_req_t sfr_in,        // sfr bus request
  input  wire logic                 global_irq_enable_in, // core enable
  input  wire logic                 cmp_rise_flag_in,   // rising edge flag
  input  wire logic                 comparator_fall_flag_in, // fall flag
  input  wire logic [NUM_CTR-1:0]   ctr_flags_in,   // counter-array flags
  input  wire logic                 adc_done_flag_in, // conversion done
  input  wire logic                 adc_win_flag_in,  // window compare
  input  wire logic                 twowire_flag_in,  // two-wire flag
  output logic [7:0]                sfr_rdata_out,  // read data
  output logic                      sfr_rvalid_out, // read data valid
  output logic [7:0]                ext_en_out,     // enable reg view
  output logic [7:0]                prio_out,       // priority reg view
  output xim_pkg::xim_src_vec_t     irq_req_out     // gated requests
);
  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  logic [7:0] ext_en_q;
  logic [7:0] prio_q;
  xim_pkg::xim_src_vec_t pend;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      ext_en_q <= `XIM_RST_EXT_EN;
    else if (sfr_in.wr && hit(sfr_in.addr, `XIM_ADDR_EXT_EN))
      ext_en_q <= sfr_in.wdata & `XIM_EXT_EN_WR_MASK;
  end

  // top two bits are unused, always read back as ones
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      prio_q <= `XIM_RST_PRIO;
    else if (sfr_in.wr && hit(sfr_in.addr, `XIM_ADDR_PRIO))
      prio_q <= (sfr_in.wdata & `XIM_PRIO_WR_MASK) | `XIM_PRIO_FIXED_ONES;
  end

  // --------------------------------------------------------------------
  // read port; unmapped addresses return zero
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      sfr_rdata_out  <= 8'h00;
      sfr_rvalid_out <= 1'b0;
    end
    else
    begin
      sfr_rvalid_out <= sfr_in.rd;
      if (sfr_in.rd && hit(sfr_in.addr, `XIM_ADDR_EXT_EN))
        sfr_rdata_out <= ext_en_q;
      else if (sfr_in.rd && hit(sfr_in.addr, `XIM_ADDR_PRIO))
        sfr_rdata_out <= prio_q;
      else
        sfr_rdata_out <= 8'h00;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      ext_en_out <= `XIM_RST_EXT_EN;
      prio_out   <= `XIM_RST_PRIO;
    end
    else
    begin
      ext_en_out <= ext_en_q;
      prio_out   <= prio_q;
    end
  end

  // --------------------------------------------------------------------
  // gating; flags are only observed, never cleared from here
  // --------------------------------------------------------------------
  always_comb
  begin
    pend = '0;
    pend[`XIM_BIT_CMP_RISE]  = cmp_rise_flag_in;         // RULE1
    pend[`XIM_BIT_CMP_FALL]  = comparator_fall_flag_in;  // RULE2
    pend[`XIM_BIT_CTR_ARRAY] = |ctr_flags_in;            // RULE3
    pend[`XIM_BIT_ADC_DONE]  = adc_done_flag_in;         // RULE4
    pend[`XIM_BIT_ADC_WIN]   = adc_win_flag_in;          // RULE5
    pend[`XIM_BIT_TWOWIRE]   = twowire_flag_in;          // RULE6
  end

  for (genvar i = 0; i < `XIM_NUM_SRC; i++)
  begin : g_src
    xim_gate u_gate (
      .clk_sys_in (clk_sys_in),
      .rst_in     (rst_in),
      .pend_in    (pend[i]),
      .en_in      (ext_en_q[i]),         // RULE8
      .glob_in    (global_irq_enable_in),
      .req_out    (irq_req_out[i])
    );
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  a_rise_masked: assert property ( // RULE1
    !ext_en_q[`XIM_BIT_CMP_RISE] |=> !irq_req_out[`XIM_BIT_CMP_RISE])
    else $error("rising request passed while masked");
  a_fall_gate: assert property ( // RULE2
    ##1 irq_req_out[`XIM_BIT_CMP_FALL] == $past(comparator_fall_flag_in
      && ext_en_q[`XIM_BIT_CMP_FALL] && global_irq_enable_in))
    else $error("falling request wrong");
  a_ctr_common: assert property ( // RULE3
    (|ctr_flags_in && ext_en_q[`XIM_BIT_CTR_ARRAY] && global_irq_enable_in)
    |=> irq_req_out[`XIM_BIT_CTR_ARRAY])
    else $error("counter array request missing");
  a_adc_done: assert property ( // RULE4
    (adc_done_flag_in && ext_en_q[`XIM_BIT_ADC_DONE]
     && global_irq_enable_in) |=> irq_req_out[`XIM_BIT_ADC_DONE])
    else $error("adc done request missing");
  a_adc_win: assert property ( // RULE5
    !ext_en_q[`XIM_BIT_ADC_WIN] |=> !irq_req_out[`XIM_BIT_ADC_WIN])
    else $error("window request passed while masked");
  a_twowire_en: assert property ( // RULE6
    (twowire_flag_in && ext_en_q[`XIM_BIT_TWOWIRE] && global_irq_enable_in)
    |=> irq_req_out[`XIM_BIT_TWOWIRE])
    else $error("two-wire request missing");
  a_global_off: assert property ( // RULE7
    !global_irq_enable_in |=> irq_req_out == '0)
    else $error("request passed with global enable low");
  a_req_cause: assert property ( // RULE8
    irq_req_out != '0 |-> $past(global_irq_enable_in)
      && ((irq_req_out & ~$past(ext_en_q[5:0])) == '0))
    else $error("request without its enable");
  a_prio_ones: assert property (
    prio_q[7:6] == 2'b11)
    else $error("priority unused bits not ones");

  a_rise_pass: assert property ( // RULE1
    (cmp_rise_flag_in && ext_en_q[`XIM_BIT_CMP_RISE] && global_irq_enable_in)
    |=> irq_req_out[`XIM_BIT_CMP_RISE])
    else $error("rising request missing");
  a_ctr_masked: assert property ( // RULE3
    !ext_en_q[`XIM_BIT_CTR_ARRAY] |=> !irq_req_out[`XIM_BIT_CTR_ARRAY])
    else $error("counter array request passed while masked");
  a_adc_masked: assert property ( // RULE4
    !ext_en_q[`XIM_BIT_ADC_DONE] |=> !irq_req_out[`XIM_BIT_ADC_DONE])
    else $error("adc done request passed while masked");
  a_win_pass: assert property ( // RULE5
    (adc_win_flag_in && ext_en_q[`XIM_BIT_ADC_WIN] && global_irq_enable_in)
    |=> irq_req_out[`XIM_BIT_ADC_WIN])
    else $error("window request missing");
  a_twowire_masked: assert property ( // RULE6
    !ext_en_q[`XIM_BIT_TWOWIRE] |=> !irq_req_out[`XIM_BIT_TWOWIRE])
    else $error("two-wire request passed while masked");
  a_no_flag: assert property ( // RULE8
    pend == '0 |=> irq_req_out == '0)
    else $error("request without a pending flag");

  // --------------------------------------------------------------------
  // register bus checks
  // --------------------------------------------------------------------
  a_en_write: assert property (
    (sfr_in.wr && hit(sfr_in.addr, `XIM_ADDR_EXT_EN))
    |=> ext_en_q == ($past(sfr_in.wdata) & `XIM_EXT_EN_WR_MASK))
    else $error("enable write did not land");
  a_en_unused: assert property (
    ext_en_q[7:6] == 2'b00)
    else $error("enable unused bits not zero");
  a_prio_write: assert property (
    (sfr_in.wr && hit(sfr_in.addr, `XIM_ADDR_PRIO))
    |=> prio_q[5:0] == $past(sfr_in.wdata[5:0]))
    else $error("priority write did not land");
  a_rd_valid: assert property (
    1'b1 |=> sfr_rvalid_out == $past(sfr_in.rd))
    else $error("read valid not one cycle after read");
  // a write in the same cycle must not leak into the read data
  a_rd_enable: assert property (
    (sfr_in.rd && hit(sfr_in.addr, `XIM_ADDR_EXT_EN))
    |=> sfr_rdata_out == $past(ext_en_q))
    else $error("enable read data wrong");
  a_rd_prio: assert property (
    (sfr_in.rd && hit(sfr_in.addr, `XIM_ADDR_PRIO))
    |=> sfr_rdata_out == $past(prio_q))
    else $error("priority read data wrong");
  a_rd_unmapped: assert property (
    (sfr_in.rd && !hit(sfr_in.addr, `XIM_ADDR_EXT_EN)
     && !hit(sfr_in.addr, `XIM_ADDR_PRIO)) |=> sfr_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_view_lag: assert property (
    1'b1 |=> ext_en_out == $past(ext_en_q) && prio_out == $past(prio_q))
    else $error("register view does not follow register");

  c_rise_req: cover property (irq_req_out[`XIM_BIT_CMP_RISE]);
  c_ctr_req:  cover property (irq_req_out[`XIM_BIT_CTR_ARRAY]);
  c_glob_blk: cover property (!global_irq_enable_in && pend != '0);
  c_en_write: cover property (sfr_in.wr
    && hit(sfr_in.addr, `XIM_ADDR_EXT_EN));
  c_rd_valid: cover property (sfr_rvalid_out);
endmodule

// ---- sim/xim_core_model.sv ----
/*
  Core-side stand-in for the mask block: drives the global enable and
  counts the cycles in which any gated request is seen.
  Assumes one system clock shared with the mask block.
*/
`timescale 1ns/1ns
module xim_core_model (
  input  wire logic           clk_sys_in,  // system clock
  input  wire logic           rst_in,      // sync reset, active high
  input  wire logic           glob_cmd_in, // wanted global enable
  input  wire xim_pkg::xim_src_vec_t irq_req_in, // gated requests
  output logic                glob_en_out, // global enable to block
  output logic [7:0]          seen_out     // request cycles seen
);
  // a level straight through: the core may flip it at any edge
  assign glob_en_out = glob_cmd_in;
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      seen_out <= 8'h00;
    else if (|irq_req_in)
      seen_out <= seen_out + 8'h01;
  end
endmodule

// ---- sim/testbench.sv ----
/*
  Self-checking bench for the extended interrupt mask block.
  Assumes the map header and package are compiled first.
*/
`timescale 1ns/1ns
`include "xim_map.svh"
module testbench;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic glob_cmd = 1'b0;
  logic [4:0] fl = 5'h00;
  logic [3:0] ctr = 4'h0;
  logic [7:0] en;
  logic [7:0] seen_prev = 8'h00;
  logic [5:0] exp_req;
  xim_pkg::xim_sfr_req_t sfr = '0;
  logic glob;
  logic [7:0] rdata, ext_en, prio, seen;
  logic rvalid;
  xim_pkg::xim_src_vec_t irq;
  integer seed = 32'hF84569A3;
  int num_errors = 0;
  int checks_done = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  xim_core_model i_core (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .glob_cmd_in(glob_cmd), .irq_req_in(irq), .glob_en_out(glob),
    .seen_out(seen));
  xim_top i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .sfr_in(sfr),
    .global_irq_enable_in(glob), .cmp_rise_flag_in(fl[4]),
    .comparator_fall_flag_in(fl[3]), .ctr_flags_in(ctr),
    .adc_done_flag_in(fl[2]), .adc_win_flag_in(fl[1]),
    .twowire_flag_in(fl[0]), .sfr_rdata_out(rdata),
    .sfr_rvalid_out(rvalid), .ext_en_out(ext_en), .prio_out(prio),
    .irq_req_out(irq));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] want(input logic [7:0] e,
    input logic g, input logic [4:0] f, input logic [3:0] c);
    return g ? ({f[4:3], |c, f[2:0]} & e[5:0]) : 6'h00;
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string n, input logic [7:0] s,
    input logic [7:0] e);
    checks_done++;
    if (s !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      num_errors++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    sfr <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys_in);
    sfr <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    int i;
    @(posedge clk_sys_in);
    sfr <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys_in);
    sfr <= '0;
    #1;
    for (i = 0; i < 4 && rvalid !== 1'b1; i++)
      @(posedge clk_sys_in) #1;
    if (i == 4)
    begin
      num_errors++;
      stop_test();
    end
    else
      check("sfr_rdata_out", rdata, e);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    #1;
    check("prio_out", prio, `XIM_RST_PRIO);
    rd(`XIM_ADDR_EXT_EN, `XIM_RST_EXT_EN);
    rd(`XIM_ADDR_PRIO, `XIM_RST_PRIO);
    rd(8'h00, 8'h00);
    wr(`XIM_ADDR_PRIO, 8'h00);
    rd(`XIM_ADDR_PRIO, 8'hC0);
    wr(`XIM_ADDR_PRIO, 8'h3F);
    rd(`XIM_ADDR_PRIO, 8'hFF);
    // single-bit masks first, then random masks, flags and global
    for (int k = 0; k < 60; k++)
    begin
      en = (k < 6) ? (8'h01 << k) : 8'($random(seed));
      wr(`XIM_ADDR_EXT_EN, en);
      fl <= (k < 6) ? 5'h1F : 5'($random(seed));
      ctr <= (k < 6) ? 4'h8 : 4'($random(seed));
      glob_cmd <= (k < 6) ? 1'b1 : 1'($random(seed));
      repeat (2) @(posedge clk_sys_in);
      #1;
      exp_req = want(en, glob_cmd, fl, ctr);
      check("irq_req_out", {2'b00, irq}, {2'b00, exp_req});
      check("irq_rise", {7'h00, irq[5]}, {7'h00, exp_req[5]});
      check("irq_fall", {7'h00, irq[4]}, {7'h00, exp_req[4]});
      check("irq_ctr", {7'h00, irq[3]}, {7'h00, exp_req[3]});
      check("irq_adc_done", {7'h00, irq[2]}, {7'h00, exp_req[2]});
      check("irq_adc_win", {7'h00, irq[1]}, {7'h00, exp_req[1]});
      check("irq_twowire", {7'h00, irq[0]}, {7'h00, exp_req[0]});
      check("ext_en_out", ext_en, en & 8'h3F);
      // corner cases keep a flag and its enable set: a request every edge
      if (k >= 1 && k < 6)
        check("seen_out", seen - seen_prev, 8'h04);
      seen_prev = seen;
    end
    rd(`XIM_ADDR_EXT_EN, en & 8'h3F);
    // reset in mid-run, flags and global enable left as they are
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    #1;
    check("irq_req_out", {2'b00, irq}, 8'h00);
    check("ext_en_out", ext_en, `XIM_RST_EXT_EN);
    check("prio_out", prio, `XIM_RST_PRIO);
    check("sfr_rdata_out", rdata, 8'h00);
    check("sfr_rvalid_out", {7'h00, rvalid}, 8'h00);
    rd(`XIM_ADDR_EXT_EN, `XIM_RST_EXT_EN);
    rd(`XIM_ADDR_PRIO, `XIM_RST_PRIO);
    stop_test();
  end
endmodule
